// ### lbm_pkg.sv
// Package for the leaky bucket activity monitor: register map, resets, timing.
// Assumes a byte-wide microprocessor register port and a 100 MHz clock.
package lbm_pkg;
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned EVAL_PERIOD_MS  = 128;
	localparam int unsigned EVAL_CYCLES     = CLK_HZ / 1000 * EVAL_PERIOD_MS;

	localparam logic [7:0] ADDR_UPPER_0     = 8'h50;
	localparam logic [7:0] ADDR_LOWER_0     = 8'h51;
	localparam logic [7:0] ADDR_CAP_0       = 8'h52;
	localparam logic [7:0] ADDR_DRAIN_0     = 8'h53;
	localparam logic [7:0] ADDR_UPPER_1     = 8'h54;
	localparam logic [7:0] ADDR_LOWER_1     = 8'h55;
	localparam logic [7:0] ADDR_CAP_1       = 8'h56;
	localparam logic [7:0] ADDR_DRAIN_1     = 8'h57;
	localparam logic [7:0] ADDR_STATUS      = 8'h58;

	localparam logic [7:0] RST_UPPER        = 8'h06;
	localparam logic [7:0] RST_LOWER        = 8'h04;
	localparam logic [7:0] RST_CAP          = 8'h08;
	localparam logic [7:0] RST_DRAIN        = 8'h01;

	localparam int unsigned DRAIN_LSB       = 0;
	localparam int unsigned DRAIN_W         = 2;
	localparam int unsigned STAT_ALARM_BIT  = 0;

	typedef struct packed {
		logic [7:0] upper;
		logic [7:0] lower;
		logic [7:0] cap;
		logic [7:0] drain;
	} lbm_cfg_type;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lbm_req_type;
endpackage

// ### lbm_bucket.sv
// One leaky bucket: accumulator, drain timer and hysteretic alarm.
// Assumes a single-cycle evaluation strobe at the end of each cycle.
`timescale 1ns/100ps
module lbm_bucket
	import lbm_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_eval,
	input  wire logic        i_bad,
	input  wire lbm_cfg_type i_cfg,
	output logic [7:0]       o_level,
	output logic             o_alarm
);
	logic [7:0] level;
	logic [2:0] clean_cnt;
	logic       alarm;
	wire  [1:0] drain_code  = i_cfg.drain[DRAIN_LSB +: DRAIN_W];
	wire  [2:0] clean_last  = 3'((4'h1 << drain_code) - 4'h1);
	wire        period_done = (clean_cnt >= clean_last);
	wire        at_cap      = (level >= i_cfg.cap);
	wire        over_cap    = (level > i_cfg.cap);
	wire        do_fill     = i_eval && i_bad && !at_cap;
	wire        do_drain    = i_eval && !i_bad && period_done
		&& (level != 8'h00);
	wire  [7:0] next_level  = over_cap ? i_cfg.cap
		: do_fill ? level + 8'h01
		: do_drain ? level - 8'h01
		: level;
	wire        next_alarm  = (next_level >= i_cfg.upper) ? 1'b1
		: (next_level <= i_cfg.lower) ? 1'b0 : alarm;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			level     <= 8'h00;
			clean_cnt <= 3'h0;
			alarm     <= 1'b0;
		end else begin
			level <= next_level;
			alarm <= next_alarm;
			if (i_eval) begin
				// A bad cycle restarts the clean period.
				clean_cnt <= (i_bad || period_done) ? 3'h0
					: clean_cnt + 3'h1;
			end
		end
	end

	assign o_level = level;
	assign o_alarm = alarm;
endmodule

// ### lbm_monitor.sv
// Leaky bucket activity monitor: register file, evaluation timer, one bucket.
// Assumes a synchronous byte register port and per-cycle bad-input reports.
`timescale 1ns/100ps
// Contract
// - Evaluate once per 128 ms cycle and update accumulator at its end.
// - Each bad evaluation cycle below the cap adds exactly one to the accumulator.
// - Drain one after 1, 2, 4 or 8 clean cycles per two-bit code.
// - Accumulator above the programmed fill cap is clamped to it on the next clock.
// - Alarm raises when accumulator reaches raise level, default six.
// - Separate parameter sets for configurations 0 and 1; cap 0 resets 8.
// - Alarm clears when accumulator is at or below reset level, default 4.
module lbm_monitor
	import lbm_pkg::*;
#(
	parameter int unsigned EVAL_CNT = EVAL_CYCLES
)(
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic       i_bad,
	input  wire logic       i_cfg_sel,
	input  wire logic       i_wr,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	output logic [7:0]      o_rdata,
	output logic            o_eval,
	output logic [7:0]      o_level,
	output logic            o_alarm
);
	lbm_cfg_type cfg0;
	lbm_cfg_type cfg1;
	logic [31:0] tick_cnt;
	logic        bad_seen;
	logic        eval;
	logic [7:0]  rdata;
	lbm_req_type req;

	assign req = '{wr: i_wr, addr: i_addr, wdata: i_wdata};

	wire tick_end = (tick_cnt == 32'(EVAL_CNT - 1));
	wire [7:0] drain_wr = {6'h00, req.wdata[DRAIN_LSB +: DRAIN_W]};
	wire [31:0] next_tick = tick_end ? 32'h0000_0000 : tick_cnt + 32'h1;
	wire        next_bad_seen = tick_end ? 1'b0 : (bad_seen | i_bad);

	// Evaluation timer and per-cycle bad flag; a report in the last cycle
	// still counts toward the cycle that is ending.
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			tick_cnt <= 32'h0000_0000;
		end else begin
			tick_cnt <= next_tick;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			eval <= 1'b0;
		end else begin
			eval <= tick_end;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			bad_seen <= 1'b0;
		end else begin
			bad_seen <= next_bad_seen;
		end
	end

	logic bad_cycle;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			bad_cycle <= 1'b0;
		end else if (tick_end) begin
			bad_cycle <= bad_seen | i_bad;
		end
	end

	// Address decode, shared by the write strobes and the read mux.
	wire hit_upper_0 = (req.addr == ADDR_UPPER_0);
	wire hit_lower_0 = (req.addr == ADDR_LOWER_0);
	wire hit_cap_0   = (req.addr == ADDR_CAP_0);
	wire hit_drain_0 = (req.addr == ADDR_DRAIN_0);
	wire hit_upper_1 = (req.addr == ADDR_UPPER_1);
	wire hit_lower_1 = (req.addr == ADDR_LOWER_1);
	wire hit_cap_1   = (req.addr == ADDR_CAP_1);
	wire hit_drain_1 = (req.addr == ADDR_DRAIN_1);
	wire hit_status  = (req.addr == ADDR_STATUS);

	wire we_upper_0  = req.wr && hit_upper_0;
	wire we_lower_0  = req.wr && hit_lower_0;
	wire we_cap_0    = req.wr && hit_cap_0;
	wire we_drain_0  = req.wr && hit_drain_0;
	wire we_upper_1  = req.wr && hit_upper_1;
	wire we_lower_1  = req.wr && hit_lower_1;
	wire we_cap_1    = req.wr && hit_cap_1;
	wire we_drain_1  = req.wr && hit_drain_1;

	logic [7:0] upper_0;
	logic [7:0] lower_0;
	logic [7:0] cap_0;
	logic [7:0] drain_0;
	logic [7:0] upper_1;
	logic [7:0] lower_1;
	logic [7:0] cap_1;
	logic [7:0] drain_1;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			upper_0 <= RST_UPPER;
		end else if (we_upper_0) begin
			upper_0 <= req.wdata;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			lower_0 <= RST_LOWER;
		end else if (we_lower_0) begin
			lower_0 <= req.wdata;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cap_0 <= RST_CAP;
		end else if (we_cap_0) begin
			cap_0 <= req.wdata;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			drain_0 <= RST_DRAIN;
		end else if (we_drain_0) begin
			drain_0 <= drain_wr;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			upper_1 <= RST_UPPER;
		end else if (we_upper_1) begin
			upper_1 <= req.wdata;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			lower_1 <= RST_LOWER;
		end else if (we_lower_1) begin
			lower_1 <= req.wdata;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cap_1 <= RST_CAP;
		end else if (we_cap_1) begin
			cap_1 <= req.wdata;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			drain_1 <= RST_DRAIN;
		end else if (we_drain_1) begin
			drain_1 <= drain_wr;
		end
	end

	assign cfg0 = '{
		upper: upper_0,
		lower: lower_0,
		cap:   cap_0,
		drain: drain_0
	};

	assign cfg1 = '{
		upper: upper_1,
		lower: lower_1,
		cap:   cap_1,
		drain: drain_1
	};

	// The selected set drives the one bucket and may change on any cycle.
	wire lbm_cfg_type cfg_act = i_cfg_sel ? cfg1 : cfg0;
	wire [7:0] level;
	wire       alarm;

	lbm_bucket u_bucket (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_eval  (eval),
		.i_bad   (bad_cycle),
		.i_cfg   (cfg_act),
		.o_level (level),
		.o_alarm (alarm)
	);

	// Read data follow the address through one register; holes read zero.
	wire [7:0] status = 8'({7'h00, alarm} << STAT_ALARM_BIT);
	wire [7:0] next_rdata =
		  hit_upper_0 ? upper_0
		: hit_lower_0 ? lower_0
		: hit_cap_0   ? cap_0
		: hit_drain_0 ? drain_0
		: hit_upper_1 ? upper_1
		: hit_lower_1 ? lower_1
		: hit_cap_1   ? cap_1
		: hit_drain_1 ? drain_1
		: hit_status  ? status
		: 8'h00;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign o_rdata = rdata;
	assign o_eval  = eval;
	assign o_level = level;
	assign o_alarm = alarm;
endmodule

// ### lbm_src.sv
// Upstream checker model: one verdict per evaluation window.
// Assumes the monitor's window length and reset.
`timescale 1ns/100ps
module lbm_src #(parameter int unsigned N = 20) (
	input  wire logic i_mclk,
	input  wire logic i_rst,
	input  wire logic i_want,
	output logic      o_bad
);
	int unsigned cnt;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt <= 0;
			o_bad <= 1'b0;
		end else begin
			cnt <= (cnt == N - 1) ? 0 : cnt + 1;
			if (cnt == N - 1) o_bad <= i_want;
		end
	end
endmodule

// ### lbm_monitor_properties.sv
// Port checker for lbm_monitor.
// Assumes one clock and an async high reset.
`timescale 1ns/100ps
module lbm_props import lbm_pkg::*; #(parameter int unsigned EVAL_CNT = 20) (
	input wire logic       i_mclk,
	input wire logic       i_rst,
	input wire logic [7:0] i_addr,
	input logic      [7:0] o_rdata,
	input logic            o_eval,
	input logic      [7:0] o_level,
	input logic            o_alarm
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	logic [31:0] gap;
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) gap <= '0;
		else gap <= o_eval ? 32'h1 : (gap != 0 ? gap + 32'h1 : '0);
	end
	sequence s_pulse; o_eval ##1 !o_eval; endsequence
	a_eval_pulse: assert property (o_eval |-> s_pulse)
		else $error("long eval");
	a_eval_period: assert property (o_eval && gap != 0 |->
		gap == EVAL_CNT) else $error("eval period");
	a_level_rise: assert property (o_level > $past(o_level) |->
		$past(o_eval) && o_level == $past(o_level) + 8'h01) else $error("rise");
	a_level_hold: assert property (!$past(o_eval) |->
		o_level <= $past(o_level)) else $error("level moved");
	a_no_wrap: assert property ($past(o_level) == 8'h00 |->
		o_level < 8'h02) else $error("wrap");
	a_alarm_raise: assert property ($rose(o_alarm) |-> $past(o_eval))
		else $error("raise");
	a_alarm_clear: assert property ($fell(o_alarm) |-> $past(o_eval))
		else $error("clear");
	a_drain_bits: assert property ($past(i_addr) == ADDR_DRAIN_0 |->
		o_rdata[7:2] == 6'h00) else $error("drain bits");
endmodule
bind lbm_monitor lbm_props #(.EVAL_CNT(EVAL_CNT)) i_props (.i_mclk, .i_rst,
	.i_addr, .o_rdata, .o_eval, .o_level, .o_alarm);

// ### lbm_monitor_test.sv
// Directed test of the monitor.
// Assumes lbm_src upstream and a short window.
`timescale 1ns/100ps
module lbm_monitor_test import lbm_pkg::*;;
	logic       i_mclk = 0, i_rst = 1, want = 0, bad, sel = 0, i_wr = 0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, o_level;
	logic       o_eval, o_alarm;
	int         error_cnt = 0, checked = 0;
	lbm_src #(.N(20)) i_src (.i_mclk, .i_rst, .i_want(want), .o_bad(bad));
	lbm_monitor #(.EVAL_CNT(20)) i_dut (.i_mclk, .i_rst, .i_bad(bad),
		.i_cfg_sel(sel), .i_wr, .i_addr, .i_wdata, .o_rdata, .o_eval,
		.o_level, .o_alarm);
	initial forever #5 i_mclk = ~i_mclk;
	task automatic close_out;
		if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(string s, logic [7:0] g, logic [7:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge i_mclk);
		i_wr <= 1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge i_mclk);
		i_addr <= a;
		repeat (3) @(posedge i_mclk);
		@(negedge i_mclk);
		chk("rdata", o_rdata, e);
	endtask
	task automatic ev(int n, int el, logic ea);
		repeat (n) begin
			@(negedge i_mclk);
			while (o_eval !== 1'b1) @(negedge i_mclk);
		end
		@(negedge i_mclk);
		chk("level", o_level, 8'(el));
		chk("alarm", {7'h00, o_alarm}, {7'h00, ea});
	endtask
	initial begin
		repeat (8) @(posedge i_mclk);
		i_rst <= 0;
		rd(ADDR_DRAIN_0, 8'h01);
		rd(ADDR_UPPER_1, 8'h06);
		rd(ADDR_CAP_0, 8'h08);
		rd(8'h59, 8'h00);
		wr(ADDR_DRAIN_0, 8'hFF);
		rd(ADDR_DRAIN_0, 8'h03);
		wr(ADDR_DRAIN_0, 8'h00);
		ev(1, 0, 0);
		want = 1;
		ev(1, 0, 0);
		for (int i = 1; i <= 10; i++) begin
			ev(1, i > 8 ? 8 : i, i >= 6);
		end
		want = 0;
		ev(1, 8, 1);
		rd(ADDR_STATUS, 8'h01);
		for (int i = 7; i >= -2; i--) begin
			ev(1, i < 0 ? 0 : i, i > 4);
		end
		for (int c = 1; c < 4; c++) begin
			wr(ADDR_DRAIN_0, 8'(c));
			want = 1;
			ev(2, 1, 0);
			want = 0;
			ev(1, 2, 0);
			ev((1 << c) - 1, 2, 0);
			ev(1, 1, 0);
			ev(1 << c, 0, 0);
		end
		wr(ADDR_CAP_1, 8'h02);
		sel <= 1;
		want = 1;
		ev(4, 2, 0);
		rd(ADDR_CAP_1, 8'h02);
		rd(ADDR_STATUS, 8'h00);
		close_out;
	end
	initial begin
		repeat (5000) @(posedge i_mclk);
		error_cnt++;
		close_out;
	end
endmodule
